// ===== verilog/ifr_input_fault.sv
/*
 * input overvoltage fault reaction with retry and delay handling, and the
 * input undervoltage warning threshold in linear format.
 * assumes ov_fault and input_voltage come from logic on clk, and that rst
 * is asserted for device reset, power cycle and loss of bias power.
 */
// Contract
// - two-bit field picks the overvoltage reaction
// - retry codes 0-6 count, 7 means unlimited
// - exhausted retries keep output latched off
// - latch clears only through reset
// - delay field picks paired delay one, two
// - warn when input voltage below threshold
// - top five bits return configured exponent
// - eleven-bit writable mantissa scaled by exponent
`timescale 1ns/10ps
`default_nettype none
`include "ifr_consts.svh"

module ifr_input_fault
   import ifr_pkg::*;
#(
   parameter int unsigned MS_CYCLES = `IFR_MS_NS / `IFR_CLK_NS,
   parameter int unsigned VOLT_W = `IFR_MANT_W + 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire ifr_pkg::ifr_addr_t reg_addr,
   input wire ifr_pkg::ifr_data_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output ifr_pkg::ifr_data_t reg_rdata,
   output logic reg_rvalid,
   input wire logic ov_fault,
   input wire logic [VOLT_W-1:0] input_voltage,
   output logic output_enable,
   output logic ov_latched,
   output logic uv_warning
);
   import ifr_pkg::*;

   logic [7:0] resp_reg_q;
   logic [7:0] exp_reg_q;
   logic [`IFR_MANT_W-1:0] mant_q;
   ifr_data_t rdata_q;
   logic rvalid_q;
   ifr_state_e st_q;
   logic [2:0] tries_q;
   logic uv_q;
   logic tmr_start;
   ifr_ms_t tmr_ms;
   logic tmr_busy;
   logic tmr_done;
   ifr_resp_e resp;
   logic [2:0] retry_code;
   logic [2:0] delay_code;
   logic [2:0] exp_n;
   logic exhausted;
   ifr_ms_t d1_ms;
   ifr_ms_t d2_ms;
   logic [VOLT_W-1:0] threshold;

   assign resp = ifr_resp_e'(resp_reg_q[`IFR_RESP_HI:`IFR_RESP_LO]);
   assign retry_code = resp_reg_q[`IFR_RETRY_HI:`IFR_RETRY_LO];
   assign delay_code = resp_reg_q[`IFR_DELAY_HI:`IFR_DELAY_LO];
   assign exp_n = exp_reg_q[`IFR_EXP_HI:`IFR_EXP_LO];
   // unlimited code never exhausts; the others allow that many restarts
   assign exhausted = (retry_code != `IFR_RETRY_INF) && (tries_q >= retry_code);

   // ****************************************************************
   // delay pairs
   // ****************************************************************
   assign d1_ms = `IFR_D1_BASE_MS << delay_code;

   always_comb begin
      case (delay_code)
         3'h0: d2_ms = `IFR_D2_0_MS;
         3'h1: d2_ms = `IFR_D2_1_MS;
         3'h2: d2_ms = `IFR_D2_2_MS;
         3'h3: d2_ms = `IFR_D2_3_MS;
         3'h4: d2_ms = `IFR_D2_4_MS;
         3'h5: d2_ms = `IFR_D2_5_MS;
         3'h6: d2_ms = `IFR_D2_6_MS;
         default: d2_ms = `IFR_D2_7_MS;
      endcase
   end

   // ****************************************************************
   // register writes
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         resp_reg_q <= `IFR_OV_RESP_RST;
         exp_reg_q <= `IFR_EXP_RST;
         mant_q <= `IFR_MANT_RST;
      end else if (reg_wr) begin
         if (reg_addr == `IFR_ADDR_OV_RESP) begin
            resp_reg_q <= reg_wdata[7:0];
         end
         if (reg_addr == `IFR_ADDR_EXP) begin
            exp_reg_q <= reg_wdata[7:0];
         end
         if (reg_addr == `IFR_ADDR_UV_WARN) begin
            mant_q <= reg_wdata[`IFR_MANT_W-1:0];
         end
      end
   end

   // ****************************************************************
   // register reads, one cycle after the strobe
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               `IFR_ADDR_OV_RESP: rdata_q <= {8'h00, resp_reg_q};
               `IFR_ADDR_EXP: rdata_q <= {8'h00, exp_reg_q};
               `IFR_ADDR_UV_WARN: rdata_q <= {2'h0, exp_n, mant_q};
               default: rdata_q <= '0;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;

   // ****************************************************************
   // undervoltage warning
   // ****************************************************************
   // threshold is mantissa times two to the exponent, kept unsigned
   assign threshold = VOLT_W'({{(VOLT_W - `IFR_MANT_W){1'b0}}, mant_q} << exp_n);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         uv_q <= 1'b0;
      end else begin
         uv_q <= input_voltage < threshold;
      end
   end

   assign uv_warning = uv_q;

   // ****************************************************************
   // overvoltage reaction
   // ****************************************************************
   always_comb begin
      tmr_start = 1'b0;
      tmr_ms = d2_ms;
      case (st_q)
         IFR_ST_RUN: begin
            if (ov_fault && resp == IFR_RESP_RIDE) begin
               tmr_start = 1'b1;
               tmr_ms = d1_ms;
            end else if (ov_fault && resp == IFR_RESP_RETRY && !exhausted) begin
               tmr_start = 1'b1;
            end
         end
         IFR_ST_RIDE: begin
            tmr_start = tmr_done && ov_fault && !exhausted;
         end
         IFR_ST_OFF: begin
            // a restart is followed by a qualifying window of delay two
            tmr_start = tmr_done;
         end
         default: tmr_start = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= IFR_ST_RUN;
      end else begin
         case (st_q)
            IFR_ST_RUN: begin
               if (ov_fault) begin
                  case (resp)
                     IFR_RESP_RIDE: st_q <= IFR_ST_RIDE;
                     IFR_RESP_RETRY: st_q <= exhausted ? IFR_ST_LATCHED : IFR_ST_OFF;
                     IFR_RESP_HOLD: st_q <= IFR_ST_HOLD;
                     default: st_q <= IFR_ST_RUN;
                  endcase
               end
            end
            IFR_ST_RIDE: begin
               if (!ov_fault) begin
                  st_q <= IFR_ST_RUN;
               end else if (tmr_done) begin
                  st_q <= exhausted ? IFR_ST_LATCHED : IFR_ST_OFF;
               end
            end
            IFR_ST_OFF: begin
               if (tmr_done) begin
                  st_q <= IFR_ST_RUN;
               end
            end
            IFR_ST_HOLD: begin
               if (!ov_fault) begin
                  st_q <= IFR_ST_RUN;
               end
            end
            IFR_ST_LATCHED: st_q <= IFR_ST_LATCHED;
            default: st_q <= IFR_ST_LATCHED;
         endcase
      end
   end

   // attempts count up per restart; a restart that survives delay two clears them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tries_q <= '0;
      end else if (st_q == IFR_ST_OFF && tmr_done) begin
         tries_q <= (tries_q == `IFR_RETRY_INF) ? tries_q : tries_q + 3'h1;
      end else if (st_q == IFR_ST_RUN && tmr_done && !ov_fault) begin
         tries_q <= '0;
      end
   end

   ifr_delay_timer #(
      .MS_CYCLES(MS_CYCLES),
      .MS_W(`IFR_MS_W)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .start(tmr_start),
      .load_ms(tmr_ms),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   assign output_enable = (st_q == IFR_ST_RUN) || (st_q == IFR_ST_RIDE);
   assign ov_latched = (st_q == IFR_ST_LATCHED);

   // ****************************************************************
   // checks
   // ****************************************************************
   chk_ignore_keeps_on: assert property (@(posedge clk) disable iff (rst)
      (st_q == IFR_ST_RUN && resp == IFR_RESP_IGNORE) |=> output_enable)
      else $error("ignore code disabled the output");
   chk_hold_releases: assert property (@(posedge clk) disable iff (rst)
      (st_q == IFR_ST_HOLD && !ov_fault) |=> output_enable)
      else $error("hold state did not re-enable after fault cleared");
   chk_unlimited_no_latch: assert property (@(posedge clk) disable iff (rst)
      (retry_code == `IFR_RETRY_INF && st_q != IFR_ST_LATCHED) |=> !ov_latched)
      else $error("latched off with unlimited retries");
   chk_latch_stays_off: assert property (@(posedge clk) disable iff (rst)
      ov_latched |=> (ov_latched && !output_enable) [*2])
      else $error("latched fault released without reset");
   chk_zero_retry_latch: assert property (@(posedge clk) disable iff (rst)
      (st_q == IFR_ST_RUN && ov_fault && resp == IFR_RESP_RETRY && retry_code == 3'h0) |=> ov_latched)
      else $error("zero retries did not latch at once");
   // off lasts exactly one delay two: the timer runs, or has just finished
   chk_restart_spacing: assert property (@(posedge clk) disable iff (rst)
      (st_q == IFR_ST_OFF) |-> tmr_busy || tmr_done)
      else $error("off state without a running delay two");
   chk_delay_pair: assert property (@(posedge clk) disable iff (rst)
      (tmr_start && st_q == IFR_ST_RUN && resp == IFR_RESP_RIDE) |-> tmr_ms == d1_ms)
      else $error("ride-through loaded the wrong delay");
   chk_uv_compare: assert property (@(posedge clk) disable iff (rst)
      ##1 uv_warning == ($past(input_voltage) < $past(threshold)))
      else $error("undervoltage warning does not follow threshold");
   chk_exp_readback: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == `IFR_ADDR_UV_WARN) |=>
         reg_rvalid && reg_rdata[`IFR_DATA_W-1:`IFR_EXPF_LO] == {2'h0, $past(exp_n)})
      else $error("exponent bits of warning threshold read wrong");

endmodule // ifr_input_fault

`default_nettype wire

// ===== common/ifr_consts.svh
/*
 * constants of the input fault retry and limit block: register map, field
 * positions, reset values and delay timings.
 * assumes it is included by bare name wherever these values are needed.
 */
`ifndef IFR_CONSTS_SVH
`define IFR_CONSTS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define IFR_ADDR_W 16
`define IFR_DATA_W 16
`define IFR_ADDR_OV_RESP 16'h0056
`define IFR_ADDR_UV_WARN 16'h0058
`define IFR_ADDR_EXP 16'hfe39

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define IFR_RESP_HI 7
`define IFR_RESP_LO 6
`define IFR_RETRY_HI 5
`define IFR_RETRY_LO 3
`define IFR_DELAY_HI 2
`define IFR_DELAY_LO 0
`define IFR_EXP_HI 5
`define IFR_EXP_LO 3
`define IFR_MANT_W 11
`define IFR_EXPF_LO 11
`define IFR_RETRY_INF 3'h7
`define IFR_OV_RESP_RST 8'h00
`define IFR_EXP_RST 8'h00
`define IFR_MANT_RST 11'h000

// ****************************************************************
// timing
// ****************************************************************
`define IFR_CLK_NS 5
`define IFR_MS_NS 1000000
`define IFR_MS_W 12
`define IFR_D1_BASE_MS 12'h00a
`define IFR_D2_0_MS 12'd252
`define IFR_D2_1_MS 12'd558
`define IFR_D2_2_MS 12'd924
`define IFR_D2_3_MS 12'd1260
`define IFR_D2_4_MS 12'd1596
`define IFR_D2_5_MS 12'd1932
`define IFR_D2_6_MS 12'd2268
`define IFR_D2_7_MS 12'd2604

`endif

// ===== common/ifr_pkg.sv
/*
 * types of the input fault retry and limit block.
 * assumes ifr_consts.svh is on the include path.
 */
`include "ifr_consts.svh"

package ifr_pkg;

   typedef logic [`IFR_ADDR_W-1:0] ifr_addr_t;
   typedef logic [`IFR_DATA_W-1:0] ifr_data_t;
   typedef logic [`IFR_MS_W-1:0] ifr_ms_t;

   // ****************************************************************
   // response codes of the overvoltage reaction field
   // ****************************************************************
   typedef enum logic [1:0] {
      IFR_RESP_IGNORE = 2'h0,
      IFR_RESP_RIDE = 2'h1,
      IFR_RESP_RETRY = 2'h2,
      IFR_RESP_HOLD = 2'h3
   } ifr_resp_e;

   // gray along run -> ride -> off -> latched
   typedef enum logic [2:0] {
      IFR_ST_RUN = 3'h0,
      IFR_ST_RIDE = 3'h1,
      IFR_ST_OFF = 3'h3,
      IFR_ST_LATCHED = 3'h2,
      IFR_ST_HOLD = 3'h6
   } ifr_state_e;

endpackage : ifr_pkg

// ===== verilog/ifr_delay_timer.sv
/*
 * millisecond delay timer: a divider makes a 1 ms enable, a counter runs down
 * the loaded number of milliseconds and pulses done at the end.
 * assumes start is a one-cycle pulse from logic on clk and load_ms is nonzero.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ifr_consts.svh"

module ifr_delay_timer #(
   parameter int unsigned MS_CYCLES = `IFR_MS_NS / `IFR_CLK_NS,
   parameter int unsigned MS_W = `IFR_MS_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [MS_W-1:0] load_ms,
   output logic busy,
   output logic done
);
   localparam int unsigned PRE_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

   logic [PRE_W-1:0] pre_q;
   logic [MS_W-1:0] cnt_q;
   logic busy_q;
   logic done_q;
   logic tick;

   assign tick = busy_q && !start && (pre_q == PRE_W'(MS_CYCLES - 1));
   assign busy = busy_q;
   assign done = done_q;

   // ****************************************************************
   // 1 ms divider, restarted with every load so a delay is never short
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_q <= '0;
      end else if (start || !busy_q || tick) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + PRE_W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= tick && (cnt_q == MS_W'(1));
         if (start) begin
            cnt_q <= load_ms;
            busy_q <= 1'b1;
         end else if (tick) begin
            cnt_q <= cnt_q - MS_W'(1);
            if (cnt_q == MS_W'(1)) begin
               busy_q <= 1'b0;
            end
         end
      end
   end

   chk_done_after_busy: assert property (@(posedge clk) disable iff (rst)
      done |-> !busy_q && $past(busy_q)) else $error("timer done without a running delay");

endmodule // ifr_delay_timer

`default_nettype wire

// ===== verif/tb_top.sv
/*
 * self-checking bench of the input fault retry and limit block: register
 * access, fault reactions, retry counting, restart spacing, warning threshold.
 * assumes the design runs with 4 clock cycles per millisecond.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ifr_consts.svh"

module tb_top;
   import ifr_pkg::*;
   localparam int unsigned MSC = 4;
   localparam int unsigned VW = `IFR_MANT_W + 8;
   localparam int D2_CYC = `IFR_D2_0_MS * MSC;
   localparam int TMO = 9000;

   logic clk = 1'b0;
   logic rst = 1'b1;
   ifr_addr_t reg_addr = '0;
   ifr_data_t reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   ifr_data_t reg_rdata;
   logic reg_rvalid;
   logic ov_fault = 1'b0;
   logic [VW-1:0] input_voltage = '0;
   logic output_enable;
   logic ov_latched;
   logic uv_warning;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   int n;

   always #2.5 clk = ~clk;

   ifr_input_fault #(.MS_CYCLES(MSC), .VOLT_W(VW)) DUT (
      .clk(clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid),
      .ov_fault(ov_fault),
      .input_voltage(input_voltage),
      .output_enable(output_enable),
      .ov_latched(ov_latched),
      .uv_warning(uv_warning)
   );

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic results();
      if (error_cnt == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input ifr_addr_t a, input ifr_data_t d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input ifr_addr_t a, input string name, input ifr_data_t exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      // the answer stands for the one cycle after the strobe edge
      @(negedge clk);
      reg_rd = 1'b0;
      check({name, "_rvalid"}, reg_rvalid, 1'b1);
      check(name, reg_rdata, exp);
   endtask

   task automatic fault(input logic v);
      @(negedge clk);
      ov_fault = v;
   endtask

   // cycles until output_enable shows v, bounded so a stuck design cannot hang here
   task automatic wait_oe(input logic v, output int cnt);
      cnt = 0;
      while (output_enable !== v && cnt < 3000) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask

   task automatic do_reset();
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == TMO) begin
         error_cnt++;
         results();
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rd(`IFR_ADDR_OV_RESP, "resp_rst", 16'h0000);
      rd(`IFR_ADDR_UV_WARN, "uv_rst", 16'h0000);
      check("oe_rst", output_enable, 1'b1);
      // ignore code: fault has no effect
      fault(1'b1);
      repeat (10) @(posedge clk);
      #1;
      check("ignore_oe", output_enable, 1'b1);
      fault(1'b0);
      // registers, exponent shown in threshold, unmapped writes dropped
      wr(`IFR_ADDR_EXP, 16'h0008);
      wr(`IFR_ADDR_UV_WARN, 16'hffff);
      wr(16'h0057, 16'h00ff);
      rd(`IFR_ADDR_EXP, "exp_reg", 16'h0008);
      rd(`IFR_ADDR_UV_WARN, "uv_full", 16'h0fff);
      rd(16'h0057, "unmapped", 16'h0000);
      // threshold 3 << 1 = 6
      wr(`IFR_ADDR_UV_WARN, 16'h0003);
      @(negedge clk);
      input_voltage = 'd5;
      repeat (3) @(posedge clk);
      #1;
      check("uv_below", uv_warning, 1'b1);
      @(negedge clk);
      input_voltage = 'd6;
      repeat (3) @(posedge clk);
      #1;
      check("uv_equal", uv_warning, 1'b0);
      // wait for clear: off while fault, back on when it goes
      wr(`IFR_ADDR_OV_RESP, 16'h00c0);
      rd(`IFR_ADDR_OV_RESP, "resp_rw", 16'h00c0);
      fault(1'b1);
      wait_oe(1'b0, n);
      check("hold_off", n <= 3, 1'b1);
      fault(1'b0);
      wait_oe(1'b1, n);
      check("hold_on", n <= 3, 1'b1);
      check("hold_latch", ov_latched, 1'b0);
      // shut down, one retry, delay code 0
      wr(`IFR_ADDR_OV_RESP, 16'h0088);
      fault(1'b1);
      wait_oe(1'b0, n);
      check("retry_off", n <= 3, 1'b1);
      fault(1'b0);
      wait_oe(1'b1, n);
      check("restart_gap", n >= D2_CYC - 2 && n <= D2_CYC + 8, 1'b1);
      fault(1'b1);
      repeat (4) @(posedge clk);
      #1;
      check("exhaust_latch", ov_latched, 1'b1);
      fault(1'b0);
      repeat (40) @(posedge clk);
      #1;
      check("stay_latch", ov_latched, 1'b1);
      check("stay_off", output_enable, 1'b0);
      do_reset();
      @(posedge clk);
      #1;
      check("clr_latch", ov_latched, 1'b0);
      check("clr_oe", output_enable, 1'b1);
      rd(`IFR_ADDR_OV_RESP, "resp_clr", 16'h0000);
      // unlimited retries never latch
      wr(`IFR_ADDR_OV_RESP, 16'h00b8);
      repeat (2) begin
         fault(1'b1);
         repeat (4) @(posedge clk);
         fault(1'b0);
         wait_oe(1'b1, n);
         check("inf_restart", n >= D2_CYC - 8 && n <= D2_CYC + 8, 1'b1);
         check("inf_latch", ov_latched, 1'b0);
      end
      // ride through for delay one, code 1 is 20 ms, no retries left
      wr(`IFR_ADDR_OV_RESP, 16'h0041);
      fault(1'b1);
      repeat (70) @(posedge clk);
      #1;
      check("ride_oe", output_enable, 1'b1);
      check("ride_latch", ov_latched, 1'b0);
      repeat (30) @(posedge clk);
      #1;
      check("ride_end", ov_latched, 1'b1);
      fault(1'b0);
      do_reset();
      // fault gone during ride leaves the output running
      wr(`IFR_ADDR_OV_RESP, 16'h0041);
      fault(1'b1);
      repeat (5) @(posedge clk);
      fault(1'b0);
      repeat (120) @(posedge clk);
      #1;
      check("ride_clear", {output_enable, ov_latched}, 2'b10);
      // shut down with zero retries latches on the first fault
      do_reset();
      wr(`IFR_ADDR_OV_RESP, 16'h0080);
      fault(1'b1);
      repeat (2) @(posedge clk);
      #1;
      check("zero_latch", {output_enable, ov_latched}, 2'b01);
      fault(1'b0);
      results();
   end
endmodule // tb_top

`default_nettype wire
